// *** design/sleag_core.sv ***
// Stack limit checking and data effective address generation
`timescale 1ns/100ps
`default_nettype none
`include "sleag_defs.svh"
// Summary of operation
// - Pointer holds first free word, grows up
// - Push stores then increments; pop decrements first
// - Call push clears pushed counter top bit
// - Exception push merges status low byte
// - Limit register unreset, bit zero reads zero
// - Every stack-pointer address compared against limit
// - Push at limit fine, next push traps
// - Pointer below 0x0800 raises underflow trap
// - Boot secure RAM only from boot code
// - Secure segment RAM only from secure code
// - File access uses 13-bit near address
// - Working register zero is default destination
// - First operand register direct, second flexible
// - Indirect address is pointer, pointer unchanged
// - Post-modify uses pointer, then adjusts it
// - Pre-modify adjusts pointer, then uses it
// - Indexed address is pointer plus base
// - Literal offset address is pointer plus literal
// - Move source, destination share offset field
// - Literal operand as 5 or 10 bits
// - Branch 16-bit signed, disable 14-bit literal
module sleag_core (
   input wire logic clk,
   input wire logic rst,
   input wire sleag_pkg::sleag_req_t req,
   input wire logic lim_we,
   input wire logic [15:0] lim_wdata,
   input wire logic lit10_sel,
   input wire logic [15:0] branch_lit,
   input wire logic [13:0] disable_interrupts_instruction_lit,
   input wire sleag_pkg::sleag_seg_t boot_seg,
   input wire sleag_pkg::sleag_seg_t sec_seg,
   output sleag_pkg::sleag_mem_t mem,
   output logic [15:0] operand_reg,
   output logic [15:0] limit_out,
   output logic [15:0] sp_out,
   output logic [15:0] branch_ofs,
   output logic [13:0] disable_interrupts_instruction_count,
   output logic stack_err,
   output logic seg_err
);
   import sleag_pkg::*;

   ////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [15:0] sext6(input logic [5:0] v);
      sext6 = {{10{v[5]}}, v};
   endfunction

   function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
      add16 = 16'(a + b);
   endfunction

   ////////////////////////////////////////////////////////////////
   // Register file, pointer and base read one cycle ahead
   logic [15:0] ptr_val;
   logic [15:0] ofs_val;
   logic rf_we;
   logic [3:0] rf_waddr;
   logic [15:0] rf_wdata;
   sleag_req_t req_reg;
   sleag_req_t req_next;

   sleag_regfile u_rf (
      .clk(clk),
      .rst(rst),
      .we(rf_we),
      .waddr(rf_waddr),
      .wdata(rf_wdata),
      .ra(req.ptr),
      .rb(req.ofs_reg),
      .da(ptr_val),
      .db(ofs_val)
   );

   ////////////////////////////////////////////////////////////////
   // Stack pointer and limit
   logic [15:0] sp_reg;
   logic [15:0] sp_next;
   logic [15:0] lim_reg;
   logic [15:0] lim_next;
   logic [15:0] ptr_cur;
   logic [15:0] ea;
   logic [15:0] ptr_upd;
   logic ptr_wb;
   logic [15:0] push_data;
   logic stk_fault;
   logic is_sp;
   logic [15:0] ofs_cur;

   always_comb begin
      req_next = req;
      lim_next = lim_reg;
      if (lim_we) begin
         lim_next = {lim_wdata[15:1], 1'b0};
      end
   end

   always_comb begin
      is_sp = req_reg.ptr == `SLEAG_SP_IDX;
      ofs_cur = (req_reg.ofs_reg == `SLEAG_SP_IDX) ? sp_reg : ofs_val;
      ptr_cur = is_sp ? sp_reg : ptr_val;
      ea = ptr_cur;
      ptr_upd = ptr_cur;
      ptr_wb = 1'b0;
      push_data = req_reg.wdata;
      if (req_reg.stk == SLEAG_ST_PUSH) begin
         ea = sp_reg;
         ptr_upd = add16(sp_reg, 16'h0002);
         ptr_wb = 1'b1;
      end else if (req_reg.stk == SLEAG_ST_POP) begin
         ea = add16(sp_reg, 16'hFFFE);
         ptr_upd = ea;
         ptr_wb = 1'b1;
      end else begin
         case (req_reg.mode)
            SLEAG_AM_FILE: begin
               ea = {3'h0, req_reg.faddr};
            end
            SLEAG_AM_IND: begin
               ea = ptr_cur;
            end
            SLEAG_AM_POST: begin
               ea = ptr_cur;
               ptr_upd = add16(ptr_cur, sext6(req_reg.pmod));
               ptr_wb = 1'b1;
            end
            SLEAG_AM_PRE: begin
               ea = add16(ptr_cur, sext6(req_reg.pmod));
               ptr_upd = ea;
               ptr_wb = 1'b1;
            end
            SLEAG_AM_IDX: begin
               ea = add16(ptr_cur, ofs_cur);
            end
            SLEAG_AM_LITOFS: begin
               ea = add16(ptr_cur, req_reg.lit);
            end
            default: begin
               ea = ptr_cur;
            end
         endcase
      end
      if (req_reg.stk == SLEAG_ST_PUSH && req_reg.ptype == SLEAG_PS_CALL) begin
         push_data = {1'b0, req_reg.pc_hi[14:0]};
      end
      if (req_reg.stk == SLEAG_ST_PUSH && req_reg.ptype == SLEAG_PS_EXC) begin
         push_data = {req_reg.status_low_byte, req_reg.pc_hi[7:0]};
      end
   end

   always_comb begin
      stk_fault = 1'b0;
      if (req_reg.valid && ((is_sp && req_reg.mode != SLEAG_AM_FILE
         && req_reg.mode != SLEAG_AM_DIRECT && req_reg.mode != SLEAG_AM_LIT)
         || req_reg.stk != SLEAG_ST_NONE)) begin
         if (ea > lim_reg || ea < `SLEAG_SFR_TOP) begin
            stk_fault = 1'b1;
         end
      end
   end

   logic boot_deny;
   logic sec_deny;
   logic mem_access;
   sleag_seg_chk u_boot (
      .addr(ea),
      .seg(boot_seg),
      .allowed(req_reg.in_boot),
      .deny(boot_deny)
   );
   sleag_seg_chk u_sec (
      .addr(ea),
      .seg(sec_seg),
      .allowed(req_reg.in_secure),
      .deny(sec_deny)
   );

   always_comb begin
      mem_access = req_reg.valid && req_reg.mode != SLEAG_AM_DIRECT
         && req_reg.mode != SLEAG_AM_LIT;
      sp_next = sp_reg;
      rf_we = 1'b0;
      rf_waddr = req_reg.ptr;
      rf_wdata = ptr_upd;
      if (req_reg.valid && ptr_wb && !stk_fault) begin
         if (is_sp || req_reg.stk != SLEAG_ST_NONE) begin
            sp_next = ptr_upd;
         end else begin
            rf_we = 1'b1;
         end
      end
      if (req_reg.valid && req_reg.to_default_working_register && !ptr_wb) begin
         rf_we = 1'b1;
         rf_waddr = `SLEAG_DEFAULT_WORKING_REGISTER_IDX;
         rf_wdata = req_reg.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Output stage
   sleag_mem_t mem_reg;
   sleag_mem_t mem_next;
   logic [15:0] opnd_reg;
   logic [15:0] opnd_next;
   logic serr_reg;
   logic serr_next;
   logic gerr_reg;
   logic gerr_next;
   logic [15:0] bofs_reg;
   logic [13:0] disable_interrupts_instruction_reg;

   always_comb begin
      mem_next = '0;
      mem_next.valid = mem_access && !stk_fault && !boot_deny && !sec_deny;
      mem_next.addr = ea;
      mem_next.wr = req_reg.wr || req_reg.stk == SLEAG_ST_PUSH;
      mem_next.wdata = push_data;
      mem_next.to_default_working_register = req_reg.to_default_working_register;
      opnd_next = ptr_cur;
      if (req_reg.mode == SLEAG_AM_LIT) begin
         opnd_next = lit10_sel ? {6'h00, req_reg.lit[9:0]} : {11'h000, req_reg.lit[4:0]};
      end
      serr_next = stk_fault;
      gerr_next = mem_access && (boot_deny || sec_deny);
   end

   always_ff @(posedge clk) begin
      lim_reg <= lim_next;
      if (rst) begin
         req_reg <= '0;
         sp_reg <= `SLEAG_SP_RST;
         mem_reg <= '0;
         opnd_reg <= 16'h0000;
         serr_reg <= 1'b0;
         gerr_reg <= 1'b0;
         bofs_reg <= 16'h0000;
         disable_interrupts_instruction_reg <= 14'h0000;
      end else begin
         req_reg <= req_next;
         sp_reg <= sp_next;
         mem_reg <= mem_next;
         opnd_reg <= opnd_next;
         serr_reg <= serr_next;
         gerr_reg <= gerr_next;
         bofs_reg <= branch_lit;
         disable_interrupts_instruction_reg <= disable_interrupts_instruction_lit;
      end
   end

   assign mem = mem_reg;
   assign operand_reg = opnd_reg;
   assign limit_out = lim_reg;
   assign sp_out = sp_reg;
   assign branch_ofs = bofs_reg;
   assign disable_interrupts_instruction_count = disable_interrupts_instruction_reg;
   assign stack_err = serr_reg;
   assign seg_err = gerr_reg;

   ////////////////////////////////////////////////////////////////
   // Checks
   chk_limit_even: assert property (@(posedge clk) disable iff (rst)
      lim_we |=> !limit_out[0]) else $error("limit bit zero set");
   chk_push_incr: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_PUSH && !stk_fault
      |=> sp_reg == $past(sp_reg) + 16'h0002) else $error("push did not increment");
   chk_pop_decr: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_POP && !stk_fault
      |=> mem.addr == sp_reg) else $error("pop address wrong");
   chk_call_msb: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_PUSH && req_reg.ptype == SLEAG_PS_CALL
      |=> !mem.wdata[15]) else $error("call push top bit set");
   chk_exc_srl: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_PUSH && req_reg.ptype == SLEAG_PS_EXC
      |=> mem.wdata[15:8] == $past(req_reg.status_low_byte)) else $error("status byte missing");
   chk_at_limit: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_PUSH && sp_reg == lim_reg
      && sp_reg >= 16'h0800 |=> !stack_err) else $error("trap at limit");
   chk_under_trap: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk != SLEAG_ST_NONE && ea < 16'h0800 ##1 !stk_fault
      |-> stack_err ##1 !stack_err) else $error("underflow not pulsed");
   chk_fault_nowr: assert property (@(posedge clk) disable iff (rst)
      stk_fault |=> !mem.valid) else $error("faulting access reached memory");
   chk_seg_block: assert property (@(posedge clk) disable iff (rst)
      mem_access && (boot_deny || sec_deny) |=> seg_err && !mem.valid)
      else $error("secure segment leaked");
   chk_sec_block: assert property (@(posedge clk) disable iff (rst)
      mem_access && sec_deny |=> seg_err && !mem.valid) else $error("secure access passed");
   chk_ind_same: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_NONE && req_reg.mode == SLEAG_AM_IND
      && is_sp && !stk_fault |=> mem.addr == sp_reg && $stable(sp_reg))
      else $error("indirect moved pointer");
   chk_post_use: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_NONE && req_reg.mode == SLEAG_AM_POST
      && is_sp && !stk_fault |=> mem.addr == $past(sp_reg)
      && sp_reg == add16($past(sp_reg), sext6($past(req_reg.pmod))))
      else $error("post-modify wrong");
   chk_pre_use: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_NONE && req_reg.mode == SLEAG_AM_PRE
      && is_sp && !stk_fault |=> mem.addr == sp_reg
      && sp_reg == add16($past(sp_reg), sext6($past(req_reg.pmod))))
      else $error("pre-modify wrong");
   chk_idx_sum: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_NONE && req_reg.mode == SLEAG_AM_IDX
      |=> mem.addr == add16($past(ptr_cur), $past(ofs_cur))) else $error("indexed sum wrong");
   chk_litofs_sum: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_NONE && req_reg.mode == SLEAG_AM_LITOFS
      |=> mem.addr == add16($past(ptr_cur), $past(req_reg.lit))) else $error("offset sum wrong");
   chk_file_near: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.stk == SLEAG_ST_NONE && req_reg.mode == SLEAG_AM_FILE
      |=> mem.addr[15:13] == 3'h0) else $error("file address beyond near space");
   chk_default_working_register_dest: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.to_default_working_register && !ptr_wb
      |=> u_rf.mem_reg[`SLEAG_DEFAULT_WORKING_REGISTER_IDX] == $past(req_reg.wdata)) else $error("default dest missed");
   chk_lit_short: assert property (@(posedge clk) disable iff (rst)
      req_reg.valid && req_reg.mode == SLEAG_AM_LIT && !lit10_sel
      |=> operand_reg[15:5] == 11'h000) else $error("short literal too wide");
   chk_branch_pass: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> branch_ofs == $past(branch_lit) && disable_interrupts_instruction_count == $past(disable_interrupts_instruction_lit))
      else $error("branch or disable literal lost");
endmodule
`default_nettype wire

// *** design/sleag_defs.svh ***
// Constants for the stack limit and effective address generator
`ifndef SLEAG_DEFS_SVH
`define SLEAG_DEFS_SVH
`define SLEAG_SFR_TOP 16'h0800
`define SLEAG_NEAR_MASK 16'h1FFF
`define SLEAG_DEFAULT_WORKING_REGISTER_IDX 4'h0
`define SLEAG_SP_IDX 4'hF
`define SLEAG_DEFAULT_WORKING_REGISTER_RST 16'h0000
`define SLEAG_SP_RST 16'h0800
`endif

// *** design/sleag_pkg.sv ***
// Types for the stack limit and effective address generator
package sleag_pkg;
   typedef enum logic [2:0] {
      SLEAG_AM_FILE = 3'h0,
      SLEAG_AM_IND = 3'h1,
      SLEAG_AM_POST = 3'h2,
      SLEAG_AM_PRE = 3'h3,
      SLEAG_AM_IDX = 3'h4,
      SLEAG_AM_LITOFS = 3'h5,
      SLEAG_AM_DIRECT = 3'h6,
      SLEAG_AM_LIT = 3'h7
   } sleag_mode_t;

   typedef enum logic [1:0] {
      SLEAG_ST_NONE = 2'h0,
      SLEAG_ST_PUSH = 2'h1,
      SLEAG_ST_POP = 2'h2
   } sleag_stk_t;

   typedef enum logic [1:0] {
      SLEAG_PS_DATA = 2'h0,
      SLEAG_PS_CALL = 2'h1,
      SLEAG_PS_EXC = 2'h2
   } sleag_push_t;

   typedef struct packed {
      logic valid;
      sleag_mode_t mode;
      logic [3:0] ptr;
      logic [3:0] ofs_reg;
      logic [15:0] lit;
      logic [5:0] pmod;
      logic wr;
      logic [12:0] faddr;
      logic to_default_working_register;
      logic [15:0] wdata;
      sleag_stk_t stk;
      sleag_push_t ptype;
      logic [15:0] pc_hi;
      logic [7:0] status_low_byte;
      logic in_boot;
      logic in_secure;
   } sleag_req_t;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic wr;
      logic [15:0] wdata;
      logic to_default_working_register;
   } sleag_mem_t;

   typedef struct packed {
      logic valid;
      logic [15:0] lo;
      logic [15:0] hi;
   } sleag_seg_t;
endpackage

// *** design/sleag_regfile.sv ***
// Sixteen-word working register file with registered read ports
`timescale 1ns/100ps
`default_nettype none
module sleag_regfile (
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [3:0] waddr,
   input wire logic [15:0] wdata,
   input wire logic [3:0] ra,
   input wire logic [3:0] rb,
   output logic [15:0] da,
   output logic [15:0] db
);
   logic [15:0] mem_reg [0:15];
   logic [15:0] da_reg;
   logic [15:0] db_reg;
   always_ff @(posedge clk) begin
      if (we) begin
         mem_reg[waddr] <= wdata;
      end
      if (rst) begin
         da_reg <= 16'h0000;
         db_reg <= 16'h0000;
      end else begin
         da_reg <= (we && waddr == ra) ? wdata : mem_reg[ra];
         db_reg <= (we && waddr == rb) ? wdata : mem_reg[rb];
      end
   end
   assign da = da_reg;
   assign db = db_reg;
endmodule
`default_nettype wire

// *** design/sleag_seg_chk.sv ***
// Secure RAM segment access check
`timescale 1ns/100ps
`default_nettype none
module sleag_seg_chk (
   input wire logic [15:0] addr,
   input wire sleag_pkg::sleag_seg_t seg,
   input wire logic allowed,
   output logic deny
);
   import sleag_pkg::*;
   always_comb begin
      deny = seg.valid && addr >= seg.lo && addr <= seg.hi && !allowed;
   end
endmodule
`default_nettype wire

// *** tb/sleag_trap_model.sv ***
// Trap logic model at the far side of the address generator
`timescale 1ns/100ps
`default_nettype none
module sleag_trap_model (
   input wire logic clk,
   input wire logic rst,
   input wire sleag_pkg::sleag_mem_t mem,
   input wire logic stack_err,
   input wire logic seg_err,
   output logic [7:0] trap_count,
   output logic [7:0] leak_count
);
   import sleag_pkg::*;
   ////////////////////////////////////////////////////////////////
   // Count trap cycles, flag leaked writes
   always_ff @(posedge clk) begin
      if (rst) begin
         trap_count <= 8'h00;
         leak_count <= 8'h00;
      end else begin
         trap_count <= trap_count + {7'h00, stack_err};
         leak_count <= leak_count + {7'h00, mem.valid & mem.wr & (stack_err | seg_err)};
      end
   end
endmodule
`default_nettype wire

// *** tb/test_stack_limit_and_ea_generation.sv ***
// Testbench for the stack limit and effective address generator
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_stack_limit_and_ea_generation;
   import sleag_pkg::*;
   logic clk, rst, lim_we, lit10_sel, stack_err, seg_err, lsel;
   logic [15:0] lim_wdata, branch_lit, operand_reg, limit_out, sp_out, branch_ofs, sp, v, bv;
   logic [13:0] disable_interrupts_instruction_lit, disable_interrupts_instruction_count, dv;
   logic [7:0] trap_count, leak_count;
   sleag_req_t req, r;
   sleag_seg_t boot_seg, sec_seg;
   sleag_mem_t mem;
   int miscompares = 0, cmp_count = 0, cyc = 0;
   sleag_core DUT (.clk(clk), .rst(rst), .req(req), .lim_we(lim_we), .lim_wdata(lim_wdata),
      .lit10_sel(lit10_sel), .branch_lit(branch_lit), .disable_interrupts_instruction_lit(disable_interrupts_instruction_lit),
      .boot_seg(boot_seg), .sec_seg(sec_seg), .mem(mem), .operand_reg(operand_reg),
      .limit_out(limit_out), .sp_out(sp_out), .branch_ofs(branch_ofs),
      .disable_interrupts_instruction_count(disable_interrupts_instruction_count), .stack_err(stack_err), .seg_err(seg_err));
   sleag_trap_model PM (.clk(clk), .rst(rst), .mem(mem), .stack_err(stack_err),
      .seg_err(seg_err), .trap_count(trap_count), .leak_count(leak_count));
   ////////////////////////////////////////////////////////////////
   function automatic sleag_req_t mk(sleag_mode_t m, sleag_stk_t s);
      sleag_req_t q;
      q = '0;
      q.valid = 1'b1;
      q.mode = m;
      q.ptr = 4'hF;
      q.ofs_reg = 4'hF;
      q.stk = s;
      return q;
   endfunction
   function automatic logic [15:0] push_word(sleag_req_t q);
      case (q.ptype)
         SLEAG_PS_CALL: return {1'b0, q.pc_hi[14:0]};
         SLEAG_PS_EXC: return {q.status_low_byte, q.pc_hi[7:0]};
         default: return q.wdata;
      endcase
   endfunction
   function automatic logic [15:0] lit_val(logic [15:0] l, logic s);
      return s ? {6'h00, l[9:0]} : {11'h000, l[4:0]};
   endfunction
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic op(input sleag_req_t q);
      bv = 16'($urandom);
      dv = 14'($urandom);
      @(posedge clk);
      req <= q;
      lit10_sel <= lsel;
      branch_lit <= bv;
      disable_interrupts_instruction_lit <= dv;
      #1;
      `CHK({stack_err, seg_err}, 2'b00)
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      #1;
   endtask
   task automatic setlim(input logic [15:0] d);
      @(posedge clk);
      lim_we <= 1'b1;
      lim_wdata <= d;
      @(posedge clk);
      lim_we <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(limit_out, d & 16'hFFFE)
   endtask
   task automatic push(input sleag_push_t t, input logic bad);
      r = mk(SLEAG_AM_IND, SLEAG_ST_PUSH);
      r.ptype = t;
      r.wr = 1'b1;
      r.wdata = 16'($urandom);
      r.pc_hi = 16'($urandom) | 16'h8000;
      r.status_low_byte = 8'($urandom);
      op(r);
      `CHK(stack_err, bad)
      `CHK(mem.valid, ~bad)
      if (!bad) `CHK(mem.addr, sp)
      if (!bad) `CHK(mem.wr, 1'b1)
      if (!bad) `CHK(mem.wdata, push_word(r))
      if (!bad) sp = sp + 16'h0002;
      `CHK(sp_out, sp)
   endtask
   task automatic pop(input logic bad);
      r = mk(SLEAG_AM_IND, SLEAG_ST_POP);
      op(r);
      `CHK(stack_err, bad)
      `CHK(mem.valid, ~bad)
      if (!bad) `CHK(mem.wr, 1'b0)
      if (!bad) sp = sp - 16'h0002;
      if (!bad) `CHK(mem.addr, sp)
      `CHK(sp_out, sp)
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      rst = 1'b1;
      req = '0;
      lim_we = 1'b0;
      lim_wdata = 16'h0000;
      lit10_sel = 1'b0;
      lsel = 1'b0;
      branch_lit = 16'h0000;
      disable_interrupts_instruction_lit = 14'h0000;
      boot_seg = '0;
      sec_seg = '0;
      sp = 16'h0800;
      v = 16'($urandom(1375));
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK(sp_out, sp)
      setlim(16'hFFFF);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK(limit_out, 16'hFFFE)
      $display("test reset done");
      push(SLEAG_PS_DATA, 1'b0);
      push(SLEAG_PS_CALL, 1'b0);
      push(SLEAG_PS_EXC, 1'b0);
      repeat (3) pop(1'b0);
      pop(1'b1);
      $display("test stack done");
      r = mk(SLEAG_AM_IND, SLEAG_ST_NONE);
      op(r);
      `CHK(mem.addr, sp)
      `CHK(sp_out, sp)
      r.mode = SLEAG_AM_POST;
      r.pmod = 6'h02;
      op(r);
      `CHK(mem.addr, sp)
      sp = sp + 16'h0002;
      `CHK(sp_out, sp)
      r.mode = SLEAG_AM_PRE;
      r.pmod = 6'h3E;
      op(r);
      sp = sp - 16'h0002;
      `CHK(mem.addr, sp)
      `CHK(sp_out, sp)
      r.mode = SLEAG_AM_IDX;
      op(r);
      `CHK(mem.addr, sp + sp)
      r.mode = SLEAG_AM_LITOFS;
      r.lit = {8'h00, 8'($urandom)} & 16'hFFFE;
      op(r);
      `CHK(mem.addr, sp + r.lit)
      $display("test modes done");
      repeat (20) begin
         r = mk(SLEAG_AM_FILE, SLEAG_ST_NONE);
         r.ptr = 4'h0;
         r.faddr = 13'($urandom);
         r.to_default_working_register = 1'($urandom);
         r.wr = ~r.to_default_working_register;
         op(r);
         `CHK(mem.addr, {3'b000, r.faddr})
         `CHK(mem.to_default_working_register, r.to_default_working_register)
         `CHK(mem.wr, r.wr)
         `CHK(mem.valid, 1'b1)
         r.mode = SLEAG_AM_LIT;
         r.lit = 16'($urandom);
         lsel = 1'($urandom);
         op(r);
         `CHK(operand_reg, lit_val(r.lit, lsel))
         `CHK({branch_ofs, disable_interrupts_instruction_count}, {bv, dv})
      end
      $display("test random done");
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         if (i == 0) boot_seg <= {1'b1, 16'h0900, 16'h09FF};
         else sec_seg <= {1'b1, 16'h0900, 16'h09FF};
         for (int j = 0; j < 2; j++) begin
            r = mk(SLEAG_AM_FILE, SLEAG_ST_NONE);
            r.faddr = 13'h0950;
            r.wr = 1'b1;
            r.in_boot = (i == 0) ? j[0] : ~j[0];
            r.in_secure = (i == 0) ? ~j[0] : j[0];
            op(r);
            `CHK(seg_err, ~j[0])
            `CHK(mem.valid, j[0])
         end
         @(posedge clk);
         boot_seg <= '0;
         sec_seg <= '0;
      end
      $display("test segments done");
      setlim(16'h0802);
      push(SLEAG_PS_DATA, 1'b0);
      push(SLEAG_PS_DATA, 1'b0);
      push(SLEAG_PS_DATA, 1'b1);
      r = mk(SLEAG_AM_IND, SLEAG_ST_NONE);
      op(r);
      `CHK(stack_err, 1'b1)
      `CHK(mem.valid, 1'b0)
      @(posedge clk);
      #1;
      `CHK({trap_count, leak_count}, 16'h0300)
      $display("test limit done");
      end_sim();
   end
endmodule
`default_nettype wire
